// ===== core/tsl_pkg.sv
/*
  Shared constants and types for the timer set-point output logic:
  register map, field positions, reset values, timing counts, modes.
  Assumes a 200 MHz pclk and 32-bit APB data with byte addresses.
*/
`default_nettype none
package tsl_pkg;
  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_HZ      = 200_000_000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYC    = TICK_MS * (CLK_HZ / 1000);
  localparam int RST_FAST_MS = 1;
  localparam int RST_SLOW_MS = 20;
  localparam int RST_FAST_CYC = RST_FAST_MS * (CLK_HZ / 1000);
  localparam int RST_SLOW_CYC = RST_SLOW_MS * (CLK_HZ / 1000);
  localparam int CNT_W       = 23;
  // ****************************************************************
  // register map (byte offsets)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SV1    = 8'h04;
  localparam logic [7:0] ADDR_SV2    = 8'h08;
  localparam logic [7:0] ADDR_PV     = 8'h0c;
  localparam logic [7:0] ADDR_STAT   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h18;
  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_HOLD     = 2;
  localparam int CTRL_SLOWRST  = 3;
  localparam int CTRL_SOFTRST  = 4;
  localparam int CTRL_START    = 5;
  localparam int STAT_FIRST    = 0;
  localparam int STAT_SECOND   = 1;
  localparam int STAT_RUN      = 2;
  localparam int IRQ_FIRST     = 0;
  localparam int IRQ_SECOND    = 1;
  localparam int IRQ_SAVED     = 2;
  localparam int SV_W          = 24;
  localparam int NVM_W         = 4 + 3 * SV_W;
  localparam logic [SV_W-1:0] SV_RST  = 24'h000000;
  localparam logic [2:0]      IRQ_RST = 3'h0;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_UP    = 2'b00,
    MODE_DOWN  = 2'b01,
    MODE_FCAST = 2'b10,
    MODE_ABS   = 2'b11
  } tsl_mode_t;
  typedef enum logic {
    NVM_IDLE = 1'b0,
    NVM_BUSY = 1'b1
  } tsl_nvm_st_t;
endpackage
`default_nettype wire

// ===== core/tsl_sync.sv
/*
  Two-flop synchroniser for a bundle of independent level inputs.
  Assumes each bit is a slow level; no multi-bit coherence is given.
*/
`default_nettype none
module tsl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== core/tsl_nvm.sv
/*
  Nonvolatile save sequencer: decides when a settings snapshot is
  written and runs a req/ack write towards the memory controller.
  Assumes the controller acks each request once, on the same clock.
*/
`default_nettype none
module tsl_nvm (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // triggers
  input  wire logic                      save_req,
  input  wire logic                      pfail,
  input  wire logic                      hold_mode,
  input  wire logic [tsl_pkg::NVM_W-1:0] snap,
  // memory side
  output logic                           nvm_wr_req,
  output logic      [tsl_pkg::NVM_W-1:0] nvm_wr_data,
  input  wire logic                      nvm_wr_ack,
  output logic                           saved
);
  import tsl_pkg::*;
  tsl_nvm_st_t st;
  logic        pf_q;
  logic        pend;
  logic        trig;
  logic        pf_rise;

  assign pf_rise = pfail && !pf_q;
  // hold modes save on power loss only, the rest on every change
  assign trig = hold_mode ? pf_rise : save_req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pf_q <= 1'b0;
    else pf_q <= pfail;
  end

  // a trigger while busy is kept so the newest snapshot still lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= NVM_IDLE;
      pend        <= 1'b0;
      nvm_wr_req  <= 1'b0;
      nvm_wr_data <= '0;
      saved       <= 1'b0;
    end else begin
      saved <= 1'b0;
      case (st)
        NVM_IDLE: begin
          if (trig || pend) begin
            nvm_wr_data <= snap;
            nvm_wr_req  <= 1'b1;
            pend        <= 1'b0;
            st          <= NVM_BUSY;
          end
        end
        NVM_BUSY: begin
          if (trig) pend <= 1'b1;
          if (nvm_wr_ack) begin
            nvm_wr_req <= 1'b0;
            saved      <= 1'b1;
            st         <= NVM_IDLE;
          end
        end
        default: st <= NVM_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  change_save_a: assert property (
    (st == NVM_IDLE && !hold_mode && save_req) |=> nvm_wr_req)
    else $error("setting change did not start a save");
  pfail_save_a: assert property (
    (st == NVM_IDLE && hold_mode && pf_rise) |=> nvm_wr_req)
    else $error("power loss in hold mode did not start a save");
  hold_nochg_a: assert property (
    (st == NVM_IDLE && hold_mode && !pf_rise && !pend)
      |=> !nvm_wr_req)
    else $error("hold mode saved without power loss");
  req_stable_a: assert property (
    (nvm_wr_req && !nvm_wr_ack)
      |=> nvm_wr_req && $stable(nvm_wr_data))
    else $error("save request dropped or changed before ack");
  save_done_c: cover property (nvm_wr_req ##[1:20] saved);
endmodule
`default_nettype wire

// ===== core/tsl_core.sv
/*
  Timer set-point output logic with APB register access: counts
  elapsed ticks, compares against set values in four modes, drives
  two stage outputs, filters the reset pin and sequences saves.
  Assumes asynchronous start/reset/power-fail pins and a memory
  controller with req/ack write and a one-shot restore at boot.
*/
// The APB interface to the registers and the register offsets were left to the implementer.
`default_nettype none
module tsl_core #(
  parameter int TICK_CYCLES     = tsl_pkg::TICK_CYC,
  parameter int RST_FAST_CYCLES = tsl_pkg::RST_FAST_CYC,
  parameter int RST_SLOW_CYCLES = tsl_pkg::RST_SLOW_CYC
) (
  // apb
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // field pins
  input  wire logic                      start_in,
  input  wire logic                      reset_in,
  input  wire logic                      power_fail_in,
  output logic                           first_stage_output,
  output logic                           second_stage_output,
  output logic                           irq,
  // nonvolatile memory
  output logic                           nvm_wr_req,
  output logic      [tsl_pkg::NVM_W-1:0] nvm_wr_data,
  input  wire logic                      nvm_wr_ack,
  input  wire logic                      nvm_rd_valid,
  input  wire logic [tsl_pkg::NVM_W-1:0] nvm_rd_data
);
  import tsl_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  tsl_mode_t        mode;
  logic             hold_mode;
  logic             slow_rst;
  logic [SV_W-1:0]  sv1;
  logic [SV_W-1:0]  sv2;
  logic [SV_W-1:0]  elapsed;
  logic [SV_W-1:0]  pv;
  logic             running;
  logic [2:0]       irq_st;
  logic [2:0]       irq_mk;
  logic [2:0]       pins_s;
  logic             start_s;
  logic             reset_s;
  logic             pfail_s;
  logic             start_q;
  logic             start_edge;
  logic [CNT_W-1:0] rst_cnt;
  logic [CNT_W-1:0] rst_lim;
  logic             rst_hit;
  logic [CNT_W-1:0] tick_cnt;
  logic             tick;
  logic             wr;
  logic             soft_rst;
  logic             sw_start;
  logic             clear;
  logic             save_req;
  logic             saved;
  logic             first_hit;
  logic             second_hit;
  logic             first_q;
  logic             second_q;
  logic [2:0]       ev;
  logic [NVM_W-1:0] snap;

  function automatic logic is_reg(input logic [7:0] a,
                                  input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return is_reg(a, ADDR_CTRL) || is_reg(a, ADDR_SV1) ||
           is_reg(a, ADDR_SV2) || is_reg(a, ADDR_PV) ||
           is_reg(a, ADDR_STAT) || is_reg(a, ADDR_IRQ_ST) ||
           is_reg(a, ADDR_IRQ_MK);
  endfunction

  function automatic logic reached(input logic [SV_W-1:0] v,
                                   input logic [SV_W-1:0] s);
    return v >= s;
  endfunction

  // ****************************************************************
  // pin synchronisers and start edge
  // ****************************************************************
  tsl_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({power_fail_in, reset_in, start_in}),
    .dout    (pins_s)
  );
  assign start_s = pins_s[0];
  assign reset_s = pins_s[1];
  assign pfail_s = pins_s[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) start_q <= 1'b0;
    else start_q <= start_s;
  end
  // a held reset pin blocks new starts
  assign start_edge = ((start_s && !start_q) || sw_start) && !reset_s;

  // ****************************************************************
  // reset pin width filter
  // ****************************************************************
  // short glitches on a noisy contact must not drop the outputs
  assign rst_lim = slow_rst ? CNT_W'(RST_SLOW_CYCLES)
                            : CNT_W'(RST_FAST_CYCLES);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rst_cnt <= '0;
    else if (!reset_s) rst_cnt <= '0;
    else if (rst_cnt != rst_lim) rst_cnt <= rst_cnt + CNT_W'(1);
  end
  assign rst_hit = reset_s && (rst_cnt == rst_lim);
  assign clear   = rst_hit || soft_rst;

  // ****************************************************************
  // apb slave
  // ****************************************************************
  assign wr       = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped(paddr);
  assign soft_rst = wr && is_reg(paddr, ADDR_CTRL) && pwdata[CTRL_SOFTRST];
  assign sw_start = wr && is_reg(paddr, ADDR_CTRL) && pwdata[CTRL_START];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode      <= MODE_UP;
      hold_mode <= 1'b0;
      slow_rst  <= 1'b0;
      sv1       <= SV_RST;
      sv2       <= SV_RST;
    end else if (wr) begin
      if (is_reg(paddr, ADDR_CTRL)) begin
        mode      <= tsl_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
        hold_mode <= pwdata[CTRL_HOLD];
        slow_rst  <= pwdata[CTRL_SLOWRST];
      end
      if (is_reg(paddr, ADDR_SV1)) sv1 <= pwdata[SV_W-1:0];
      if (is_reg(paddr, ADDR_SV2)) sv2 <= pwdata[SV_W-1:0];
    end else if (nvm_rd_valid) begin
      mode      <= tsl_mode_t'(nvm_rd_data[NVM_W-1 -: 2]);
      hold_mode <= nvm_rd_data[NVM_W-3];
      slow_rst  <= nvm_rd_data[NVM_W-4];
      sv1       <= nvm_rd_data[3*SV_W-1 -: SV_W];
      sv2       <= nvm_rd_data[2*SV_W-1 -: SV_W];
    end
  end

  // read data is captured in the setup cycle so the answer is
  // registered and still comes with zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      case (paddr)
        ADDR_CTRL:   prdata <= {28'h0000000, slow_rst, hold_mode, mode};
        ADDR_SV1:    prdata <= {8'h00, sv1};
        ADDR_SV2:    prdata <= {8'h00, sv2};
        ADDR_PV:     prdata <= {8'h00, pv};
        ADDR_STAT:   prdata <= {29'h00000000, running,
                                second_stage_output, first_stage_output};
        ADDR_IRQ_ST: prdata <= {29'h00000000, irq_st};
        ADDR_IRQ_MK: prdata <= {29'h00000000, irq_mk};
        default:     prdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // timing base
  // ****************************************************************
  assign tick = running && (tick_cnt == CNT_W'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt <= '0;
    else if (clear || start_edge || tick || !running) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + CNT_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) running <= 1'b0;
    else if (clear) running <= 1'b0;
    else if (start_edge) running <= 1'b1;
  end

  // hold modes accumulate across starts; only a reset zeroes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) elapsed <= SV_RST;
    else if (clear) elapsed <= SV_RST;
    else if (nvm_rd_valid && !wr) elapsed <= nvm_rd_data[SV_W-1:0];
    else if (start_edge && !hold_mode) elapsed <= SV_RST;
    else if (tick && elapsed != {SV_W{1'b1}}) elapsed <= elapsed + 24'h000001;
  end

  // ****************************************************************
  // compare and output logic
  // ****************************************************************
  // the set values are re-read every cycle, so a new set value at or
  // below the elapsed count switches the output on at once
  always_comb begin
    first_hit  = 1'b0;
    second_hit = 1'b0;
    case (mode)
      MODE_UP:    second_hit = reached(elapsed, sv1);
      MODE_DOWN:  second_hit = reached(elapsed, sv1);
      MODE_FCAST: begin
        second_hit = reached(elapsed, sv1);
        first_hit  = reached(elapsed, (sv1 > sv2) ? sv1 - sv2
                                                  : SV_RST);
      end
      MODE_ABS: begin
        second_hit = reached(elapsed, sv2);
        first_hit  = reached(elapsed, sv1);
      end
      default: begin
        first_hit  = 1'b0;
        second_hit = 1'b0;
      end
    endcase
  end

  // outputs latch on until a reset; a zero set value hits as soon as
  // the start edge makes the block run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_stage_output  <= 1'b0;
      second_stage_output <= 1'b0;
    end else if (clear) begin
      first_stage_output  <= 1'b0;
      second_stage_output <= 1'b0;
    end else if (running) begin
      if (first_hit) first_stage_output <= 1'b1;
      if (second_hit) second_stage_output <= 1'b1;
    end
  end

  // down mode shows the remaining time; deriving it from the set
  // value adds any set-value change straight to the present value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pv <= SV_RST;
    else if (mode != MODE_DOWN) pv <= elapsed;
    else if (reached(elapsed, sv1)) pv <= SV_RST;
    else pv <= sv1 - elapsed;
  end

  // ****************************************************************
  // interrupts and saves
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q  <= 1'b0;
      second_q <= 1'b0;
      save_req <= 1'b0;
    end else begin
      first_q  <= first_stage_output;
      second_q <= second_stage_output;
      // one cycle late so the snapshot holds the written value
      save_req <= wr && (is_reg(paddr, ADDR_CTRL) ||
                  is_reg(paddr, ADDR_SV1) || is_reg(paddr, ADDR_SV2));
    end
  end

  assign ev = {saved, second_stage_output && !second_q,
               first_stage_output && !first_q};

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st <= IRQ_RST;
      irq_mk <= IRQ_RST;
    end else begin
      if (wr && is_reg(paddr, ADDR_IRQ_MK)) irq_mk <= pwdata[2:0];
      if (wr && is_reg(paddr, ADDR_IRQ_ST))
        irq_st <= (irq_st & ~pwdata[2:0]) | ev;
      else irq_st <= irq_st | ev;
    end
  end
  assign irq = |(irq_st & irq_mk);

  assign snap = {mode, hold_mode, slow_rst, sv1, sv2, elapsed};

  tsl_nvm u_nvm (
    .pclk        (pclk),
    .presetn     (presetn),
    .save_req    (save_req),
    .pfail       (pfail_s),
    .hold_mode   (hold_mode),
    .snap        (snap),
    .nvm_wr_req  (nvm_wr_req),
    .nvm_wr_data (nvm_wr_data),
    .nvm_wr_ack  (nvm_wr_ack),
    .saved       (saved)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  clear_off_a: assert property (clear |=> !first_stage_output &&
                                !second_stage_output)
    else $error("outputs not off after reset");
  pin_reset_a: assert property ((reset_s && rst_cnt == rst_lim)
                 |=> !second_stage_output && !first_stage_output)
    else $error("filtered reset pin did not clear outputs");
  up_on_a: assert property ((running && !clear && mode == MODE_UP &&
                 elapsed >= sv1) |=> second_stage_output)
    else $error("up mode output late");
  down_zero_a: assert property ((mode == MODE_DOWN && running && !clear
                 && elapsed >= sv1) |=> pv == 24'h000000 &&
                 second_stage_output)
    else $error("down mode did not reach zero with output on");
  down_shift_a: assert property ((mode == MODE_DOWN && elapsed < sv1)
                 |=> pv == $past(sv1) - $past(elapsed))
    else $error("remaining time not shifted by set change");
  fcast_ctl_a: assert property ((running && !clear && mode == MODE_FCAST
                 && elapsed >= sv1) |=> second_stage_output)
    else $error("forecast control output late");
  fcast_warn_a: assert property ((running && !clear && mode == MODE_FCAST
                 && sv1 > sv2 && elapsed >= sv1 - sv2)
                 |=> first_stage_output)
    else $error("forecast warning output late");
  abs_second_a: assert property ((running && !clear && mode == MODE_ABS
                 && elapsed >= sv2) |=> second_stage_output)
    else $error("absolute second output late");
  abs_first_a: assert property ((running && !clear && mode == MODE_ABS
                 && elapsed < sv1) |=> !$rose(first_stage_output))
    else $error("absolute first output before its set value");
  zero_start_a: assert property ((start_edge && !clear && sv1 == SV_RST
                 && mode == MODE_UP && !wr) ##1 (!clear && !wr)
                 |=> second_stage_output)
    else $error("zero set value output not on at start");
  up_out_c: cover property (mode == MODE_UP ##1 $rose(second_stage_output));
  down_out_c: cover property (mode == MODE_DOWN &&
                              $rose(second_stage_output));
  abs_both_c: cover property (mode == MODE_ABS && first_stage_output &&
                              second_stage_output);
  pin_reset_c: cover property (rst_hit && second_stage_output);
endmodule
`default_nettype wire

// ===== dv/tsl_nvm_model.sv
/*
  Memory controller model for the save port: acks each write,
  alternating prompt and slow answers, and counts the saves.
  Assumes req is held until ack; the kept snapshot is restored once
  after every reset.
*/
`default_nettype none
module tsl_nvm_model (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // memory port
  input  wire logic                      nvm_wr_req,
  input  wire logic [tsl_pkg::NVM_W-1:0] nvm_wr_data,
  output logic                           nvm_wr_ack,
  output logic                           nvm_rd_valid,
  output logic      [tsl_pkg::NVM_W-1:0] nvm_rd_data,
  output int                             saves
);
  timeunit 1ns;
  timeprecision 1ps;
  import tsl_pkg::*;
  // the store is the memory itself and must outlive every reset
  logic [NVM_W-1:0] store = '0;
  int               wait_cnt;
  logic             slow;
  logic             booted;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {nvm_wr_ack, nvm_rd_valid, slow, booted} <= 4'h0;
      nvm_rd_data <= '0;
      saves <= 0;
      wait_cnt <= 2;
    end else begin
      nvm_wr_ack <= 1'b0;
      booted <= 1'b1;
      // one restore pulse per boot; idle read lines never hold a value
      nvm_rd_valid <= !booted;
      nvm_rd_data <= booted ? ~nvm_rd_data : store;
      if (nvm_wr_req && !nvm_wr_ack) begin
        if (wait_cnt == 0) begin
          nvm_wr_ack <= 1'b1;
          store <= nvm_wr_data;
          saves <= saves + 1;
          slow <= !slow;
          wait_cnt <= slow ? 1 : 6;
        end else begin
          wait_cnt <= wait_cnt - 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tsl_core_tb_top.sv
/*
  Self-checking bench for the timer set-point logic: APB master,
  field pins, a read scoreboard and the memory model.
  Assumes shortened tick and filter counts set at the instance.
*/
`default_nettype none
module tsl_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tsl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic start_in, reset_in, power_fail_in, nvm_wr_req, nvm_wr_ack;
  logic first_stage_output, second_stage_output, nvm_rd_valid;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, r, seed, eq[$], mq[$];
  logic [NVM_W-1:0] nvm_wr_data, nvm_rd_data;
  int               saves, errors, n_compared, s0;
  tsl_core #(.TICK_CYCLES(8), .RST_FAST_CYCLES(20), .RST_SLOW_CYCLES(60))
    u_tsl_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .start_in, .reset_in,
    .power_fail_in, .first_stage_output, .second_stage_output, .irq,
    .nvm_wr_req, .nvm_wr_data, .nvm_wr_ack, .nvm_rd_valid, .nvm_rd_data);
  tsl_nvm_model u_tsl_nvm_model (.pclk, .presetn, .nvm_wr_req,
    .nvm_wr_data, .nvm_wr_ack, .nvm_rd_valid, .nvm_rd_data, .saves);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task give_verdict();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // expectation is noted first; the monitor below compares it
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready)
      chk(pslverr, paddr > ADDR_IRQ_MK);
    if (psel && penable && pready && !pwrite) begin
      r = prdata & mq.pop_front();
      chk(r, eq.pop_front());
    end
  end
  initial begin
    tick(4000);
    errors++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, start_in, reset_in, power_fail_in} = 6'h0;
    {paddr, pwdata, presetn} = '0;
    {seed, errors, n_compared} = {32'h4537c15a, 64'h0};
    tick(5);
    presetn <= 1'b1;
    tick(2);
    rd(ADDR_SV1, 0, '1);
    rd(ADDR_IRQ_ST, 0, '1);
    rd(8'h1c, 0, '1);
    $display("done: reset values");
    start_in <= 1'b1;
    tick(5);
    chk(second_stage_output, 1);
    {start_in, reset_in} <= 2'b01;
    tick(5);
    reset_in <= 1'b0;
    tick(5);
    chk(second_stage_output, 1);
    reset_in <= 1'b1;
    tick(26);
    chk({first_stage_output, second_stage_output}, 0);
    reset_in <= 1'b0;
    tick(4);
    $display("done: reset pin");
    wr(ADDR_SV1, 1000);
    wr(ADDR_CTRL, 32'h20);
    tick(48);
    rd(ADDR_STAT, 0, 2);
    wr(ADDR_SV1, 1 + xs() % 4);
    rd(ADDR_STAT, 2, 2);
    wr(ADDR_CTRL, 32'h11);
    wr(ADDR_SV1, 100);
    wr(ADDR_CTRL, 32'h21);
    wr(ADDR_SV1, 527);
    rd(ADDR_PV, 32'h208, 32'hfffff8);
    tick(40);
    wr(ADDR_SV1, 3);
    rd(ADDR_PV, 0, '1);
    rd(ADDR_STAT, 2, 2);
    $display("done: up and down");
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, 32'h12 + i);
      wr(ADDR_SV1, 10);
      wr(ADDR_SV2, 4 + i);
      wr(ADDR_CTRL, 32'h22 + i);
      tick(64);
      rd(ADDR_STAT, 1 + i, 3);
      tick(40);
      rd(ADDR_STAT, 3, 3);
    end
    $display("done: two outputs");
    wr(ADDR_CTRL, 32'h10);
    tick(12);
    wr(ADDR_IRQ_ST, 7);
    s0 = saves;
    wr(ADDR_SV2, 7);
    tick(12);
    chk(saves, s0 + 1);
    chk(irq, 0);
    wr(ADDR_IRQ_MK, 4);
    tick(1);
    chk(irq, 1);
    wr(ADDR_IRQ_ST, 4);
    tick(1);
    chk(irq, 0);
    wr(ADDR_CTRL, 32'h4);
    tick(12);
    s0 = saves;
    wr(ADDR_SV1, 5);
    tick(12);
    chk(saves, s0);
    power_fail_in <= 1'b1;
    tick(14);
    chk(saves, s0 + 1);
    $display("done: saves");
    {presetn, power_fail_in} <= 2'b00;
    tick(3);
    presetn <= 1'b1;
    tick(2);
    rd(ADDR_SV1, 5, '1);
    rd(ADDR_SV2, 7, '1);
    rd(ADDR_CTRL, 32'h4, '1);
    wr(ADDR_CTRL, 32'h2c);
    tick(48);
    reset_in <= 1'b1;
    tick(40);
    chk(second_stage_output, 1);
    tick(30);
    chk(second_stage_output, 0);
    reset_in <= 1'b0;
    $display("done: restore and slow filter");
    give_verdict();
  end
endmodule
`default_nettype wire
